// File: rpos_pkg.sv
// Constants and carrier types for the remappable pin output selector
package rpos_pkg;

    localparam int RPOS_NUM_REGS = 6;
    localparam int RPOS_NUM_PINS = 12;
    localparam int RPOS_FIRST_PIN = 14;
    localparam int RPOS_FIRST_REG_NUM = 7;
    localparam int RPOS_CODE_W = 5;
    localparam int RPOS_NUM_CODES = 32;
    localparam int RPOS_REG_W = 16;
    localparam int RPOS_ADDR_W = 12;
    localparam int RPOS_IDX_W = 3;

    // Byte offsets, one aligned word per register
    localparam logic [11:0] RPOS_OFS_14_15 = 12'h000;
    localparam logic [11:0] RPOS_OFS_16_17 = 12'h004;
    localparam logic [11:0] RPOS_OFS_18_19 = 12'h008;
    localparam logic [11:0] RPOS_OFS_20_21 = 12'h00C;
    localparam logic [11:0] RPOS_OFS_22_23 = 12'h010;
    localparam logic [11:0] RPOS_OFS_24_25 = 12'h014;

    // Field layout
    localparam int RPOS_EVEN_LSB = 0;
    localparam int RPOS_ODD_LSB = 8;
    localparam logic [15:0] RPOS_IMPL_MASK = 16'h1F1F;
    localparam logic [15:0] RPOS_RESET = 16'h0000;
    localparam logic [4:0] RPOS_CODE_NONE = 5'h00;

    // Default set of codes that name a peripheral output
    localparam logic [31:0] RPOS_FUNC_PRESENT = 32'hFFFFFFFE;

    // AHB encodings
    localparam logic [1:0] RPOS_HTRANS_IDLE = 2'h0;
    localparam logic RPOS_HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
        logic [2:0] idx;
    } rpos_req_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic periph;
    } rpos_pin_t;

endpackage

// File: rpos_select.sv
// Remappable pin output selector, pins 14 to 25, with an AHB-Lite slave
`timescale 1ns/100ps
module rpos_select
    import rpos_pkg::*;
#(
    parameter logic [31:0] FUNC_PRESENT = RPOS_FUNC_PRESENT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [RPOS_ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [RPOS_NUM_CODES-1:0] func_out,
    input wire logic [RPOS_NUM_CODES-1:0] func_oe,
    input wire logic [RPOS_NUM_PINS-1:0] gpio_out,
    input wire logic [RPOS_NUM_PINS-1:0] gpio_oe,
    output logic [RPOS_NUM_PINS-1:0] pin_out,
    output logic [RPOS_NUM_PINS-1:0] pin_oe,
    output logic [RPOS_NUM_PINS-1:0] pin_periph
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check

    generate
        if (FUNC_PRESENT[0] != 1'b0) begin : g_bad_present
            $error("Code zero must not name a peripheral");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Address decode to register index
    function automatic logic [3:0] decode(input logic [RPOS_ADDR_W-1:0] a);
        logic [RPOS_ADDR_W-3:0] w;
        w = a[RPOS_ADDR_W-1:2];
        if (a[1:0] == 2'h0 && w < (RPOS_ADDR_W-2)'(RPOS_NUM_REGS)) begin
            decode = {1'b1, w[2:0]};
        end else begin
            decode = 4'h0;
        end
    endfunction

    // Selection field of one pin
    function automatic logic [4:0] field(input logic [15:0] r,
                                         input logic odd);
        field = odd ? r[RPOS_ODD_LSB +: RPOS_CODE_W]
                    : r[RPOS_EVEN_LSB +: RPOS_CODE_W];
    endfunction

    // Code names a present peripheral output
    function automatic logic present(input logic [4:0] c);
        present = (c != RPOS_CODE_NONE) && FUNC_PRESENT[c];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus request capture

    rpos_req_t req_r;
    rpos_req_t req_nxt;
    logic accept;
    logic [3:0] dec;

    assign accept = hsel && htrans[1] && hready;
    assign dec = decode(haddr);

    always_comb begin
        req_nxt.valid = accept;
        req_nxt.write = hwrite;
        req_nxt.hit = dec[3];
        req_nxt.idx = dec[2:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Selection registers

    logic [15:0] sel_r [RPOS_NUM_REGS];
    logic [15:0] sel_nxt [RPOS_NUM_REGS];
    logic wr_now;
    logic [15:0] wr_val;

    assign wr_now = req_r.valid && req_r.write && req_r.hit;
    assign wr_val = hwdata[15:0] & RPOS_IMPL_MASK;

    always_comb begin
        for (int i = 0; i < RPOS_NUM_REGS; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        if (wr_now) begin
            sel_nxt[req_r.idx] = wr_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < RPOS_NUM_REGS; i++) begin
                sel_r[i] <= RPOS_RESET;
            end
        end else begin
            for (int i = 0; i < RPOS_NUM_REGS; i++) begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;

    always_comb begin
        hrdata_nxt = 32'h00000000;
        // Read back, with a pending write forwarded
        if (accept && !hwrite && dec[3]) begin
            if (wr_now && req_r.idx == dec[2:0]) begin
                hrdata_nxt = {16'h0000, wr_val};
            end else begin
                hrdata_nxt = {16'h0000, sel_r[dec[2:0]] & RPOS_IMPL_MASK};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else begin
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = RPOS_HRESP_OKAY;

    ////////////////////////////////////////////////////////////////////////
    // Pin mux

    rpos_pin_t pin_r [RPOS_NUM_PINS];
    rpos_pin_t pin_nxt [RPOS_NUM_PINS];

    always_comb begin
        for (int p = 0; p < RPOS_NUM_PINS; p++) begin
            logic [4:0] c;
            // Odd pin upper field, even pin lower
            c = field(sel_r[p / 2], p[0]);
            // Otherwise port logic keeps the pin
            if (present(c)) begin
                pin_nxt[p].out = func_out[c];
                pin_nxt[p].oe = func_oe[c];
                pin_nxt[p].periph = 1'b1;
            end else begin
                pin_nxt[p].out = gpio_out[p];
                pin_nxt[p].oe = gpio_oe[p];
                pin_nxt[p].periph = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < RPOS_NUM_PINS; p++) begin
                pin_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < RPOS_NUM_PINS; p++) begin
                pin_r[p] <= pin_nxt[p];
            end
        end
    end

    always_comb begin
        for (int p = 0; p < RPOS_NUM_PINS; p++) begin
            pin_out[p] = pin_r[p].out;
            pin_oe[p] = pin_r[p].oe;
            pin_periph[p] = pin_r[p].periph;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [4:0] chk_code16;
    assign chk_code16 = sel_r[1][4:0];

    a_pad_bits_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (hrdata & ~{16'h0000, RPOS_IMPL_MASK}) == 32'h00000000)
        else $error("Unimplemented bits read nonzero");

    a_reset_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !$past(hresetn) |-> pin_periph == '0 && sel_r[0] == RPOS_RESET
            && sel_r[5] == RPOS_RESET)
        else $error("Codes not clear after reset");

    a_write_stores: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_now |=> sel_r[$past(req_r.idx)] == $past(wr_val))
        else $error("Written value not stored");

    a_read_returns: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && dec[3] && !wr_now)
        |=> hrdata[15:0] == $past(sel_r[dec[2:0]]))
        else $error("Read data differs from register");

    a_field_even_odd: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 pin_periph[0] == $past(present(sel_r[0][4:0]))
            && pin_periph[1] == $past(present(sel_r[0][12:8])))
        else $error("Field layout wrong for pins 14 and 15");

    a_route_func: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 pin_periph[2] |-> pin_out[2] == $past(func_out[chk_code16])
            && pin_oe[2] == $past(func_oe[chk_code16]))
        else $error("Pin 16 not driven by selected peripheral");

    a_gpio_default: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 !pin_periph[3] |-> pin_out[3] == $past(gpio_out[3])
            && pin_oe[3] == $past(gpio_oe[3]))
        else $error("Pin 17 not left to port logic");

    a_last_reg_map: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_now && req_r.idx == 3'h5 && present(wr_val[12:8]))
        |=> ##1 pin_periph[11])
        else $error("Last register does not steer pin 25");

    a_bus_okay: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && hresp == RPOS_HRESP_OKAY)
        else $error("Bus response not ready and okay");

    a_store_masked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((sel_r[0] | sel_r[1] | sel_r[2] | sel_r[3] | sel_r[4] | sel_r[5])
            & ~RPOS_IMPL_MASK) == 16'h0000)
        else $error("Unimplemented bits stored");

    a_unmapped_ignored: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (req_r.valid && req_r.write && !req_r.hit)
        |=> sel_r[0] == $past(sel_r[0]) && sel_r[5] == $past(sel_r[5]))
        else $error("Unmapped write changed a register");

    a_unmapped_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && !dec[3]) |=> hrdata == 32'h00000000)
        else $error("Unmapped read returned nonzero");

    a_zero_code_port: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sel_r[5][12:8] == RPOS_CODE_NONE |=> !pin_periph[11])
        else $error("Code zero gave pin 25 to a peripheral");

    c_write_reg: cover property (
        @(posedge hclk) disable iff (!hresetn) wr_now);

    c_read_fwd: cover property (
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && dec[3] && wr_now && req_r.idx == dec[2:0]);

    c_pin_periph: cover property (
        @(posedge hclk) disable iff (!hresetn) pin_periph[11]);

    c_unmapped: cover property (
        @(posedge hclk) disable iff (!hresetn) accept && !dec[3]);

    c_absent_code: cover property (
        @(posedge hclk) disable iff (!hresetn)
        sel_r[0][4:0] != RPOS_CODE_NONE && !present(sel_r[0][4:0]));

endmodule // rpos_select

// File: tb_top.sv
// Self-checking testbench for the remappable pin output selector
`timescale 1ns/100ps
module tb_top;
    import rpos_pkg::*;
    // Codes 8 to 15 name no peripheral here
    localparam logic [31:0] FP = 32'hFFFF00FE;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr, go, goe, pin_out, pin_oe, pin_periph;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, fo, foe, seed, rd, d;
    logic [15:0] model [RPOS_NUM_REGS];
    int n_fail, checked, k;
    assign hready = hreadyout;
    ////////////////////////////////////////////////////////////////////////
    rpos_select #(.FUNC_PRESENT(FP)) i_rpos_select (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .func_out(fo), .func_oe(foe), .gpio_out(go),
        .gpio_oe(goe), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_periph(pin_periph));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected periph, enable and level of all twelve pins
    function automatic logic [35:0] exp_pins();
        logic [11:0] o, e, p;
        logic [4:0] c;
        for (int i = 0; i < 12; i++) begin
            c = model[i / 2][(i % 2) * 8 +: 5];
            p[i] = (c != 5'h00) && FP[c];
            o[i] = p[i] ? fo[c] : go[i];
            e[i] = p[i] ? foe[c] : goe[i];
        end
        return {p, e, o};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (model[j]) model[j] = 16'h0000;
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        cmp_resp();
    endtask
    task automatic cmp_resp();
        checked++;
        if ({hreadyout, hresp} !== {1'b1, RPOS_HRESP_OKAY}) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                     {hreadyout, hresp}, {1'b1, RPOS_HRESP_OKAY});
        end
    endtask
    task automatic cmp_rd(input logic [31:0] exp);
        checked++;
        if (rd !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rd, exp);
        end
    endtask
    task automatic cmp_pin(input logic [35:0] exp);
        checked++;
        if ({pin_periph, pin_oe, pin_out} !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                     {pin_periph, pin_oe, pin_out}, exp);
        end
    endtask
    task automatic read_all();
        for (int j = 0; j < RPOS_NUM_REGS; j++) begin
            bus(1'b0, 12'(j * 4), 32'h00000000);
            cmp_rd({16'h0000, model[j]});
        end
        bus(1'b0, 12'h018, 32'h00000000);
        cmp_rd(32'h00000000);
    endtask
    task automatic pin_test();
        @(posedge hclk);
        fo <= rnd();
        foe <= rnd();
        go <= 12'(rnd());
        goe <= 12'(rnd());
        repeat (2) @(posedge hclk);
        cmp_pin(exp_pins());
    endtask
    task automatic print_verdict();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge hclk);
        n_fail++;
        print_verdict();
    end
    initial begin
        seed = 32'h0000E4DB;
        n_fail = 0;
        checked = 0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {fo, foe, go, goe} = '0;
        do_reset();
        read_all();
        pin_test();
        $display("test reset values done");
        for (int j = 0; j < RPOS_NUM_REGS; j++) begin
            bus(1'b1, 12'(j * 4), 32'hFFFFE1FF);
            model[j] = 16'hE1FF & RPOS_IMPL_MASK;
        end
        read_all();
        pin_test();
        $display("test unimplemented bits done");
        for (int n = 0; n < 48; n++) begin
            k = int'(rnd() % 32'h00000006);
            d = rnd();
            if (n % 4 == 0)
                d[12:8] = 5'h00;
            bus(1'b1, 12'(k * 4), d);
            model[k] = d[15:0] & RPOS_IMPL_MASK;
            pin_test();
        end
        bus(1'b1, 12'h018, 32'hFFFFFFFF);
        read_all();
        $display("test random codes done");
        do_reset();
        read_all();
        pin_test();
        $display("test second reset done");
        print_verdict();
    end
endmodule // tb_top
